// ===== hw/sceh_pkg.sv
/*
 * Constants shared by the communication error handler and its bench.
 * Assumes one 25 MHz clock and a frame front end on the same clock.
 */
`default_nettype none
package sceh_pkg;
	// Status register address and layout.
	localparam logic [15:0] ERR_STATUS_ADDR  = 16'h0219;
	localparam logic [7:0]  ERR_STATUS_RESET = 8'h00;
	localparam int          FLAG_W           = 7;
	localparam int          BIT_FRAMING      = 0;
	localparam int          BIT_HEADER       = 1;
	localparam int          BIT_RW_PARITY    = 2;
	localparam int          BIT_LEN_PARITY   = 3;
	localparam int          BIT_CHECKSUM     = 4;
	localparam int          BIT_TIMEOUT      = 5;
	localparam int          BIT_RW_DATA      = 6;

	// Field timing; the field time is a plain default.
	localparam int CLK_PERIOD_NS  = 40;
	localparam int FIELD_TIME_NS  = 40000;
	localparam int FIELD_CYCLES   = (FIELD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_FIELDS     = 3;
	localparam int RECOVER_FIELDS = 4;

	typedef enum logic [1:0] {
		ST_STANDBY = 2'b00,
		ST_COMM    = 2'b01,
		ST_ERROR   = 2'b10
	} sceh_state_e;
endpackage : sceh_pkg
`default_nettype wire

// ===== hw/sceh_span_timer.sv
/*
 * Span timer: counts consecutive cycles of a run level and flags once the
 * count is longer than a limit. Assumes run is a level on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module sceh_span_timer #(
	parameter int W     = 16,
	parameter int LIMIT = 1000
) (
	// Clock and reset.
	input  wire logic ref_clk,
	input  wire logic rst,
	// Timing.
	input  wire logic run,
	output logic      expired
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;

	// The count must reach LIMIT + 1 without wrapping.
	if (LIMIT < 1 || LIMIT + 1 >= (1 << W)) begin : g_bad_limit
		$error("sceh_span_timer: LIMIT does not fit W");
	end

	// Saturating so the flag stays up while run holds.
	always_comb begin
		count_nxt = count_r;
		if (!run) begin
			count_nxt = '0;
		end else if (!expired) begin
			count_nxt = count_r + W'(1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign expired = (count_r > W'(LIMIT));
endmodule : sceh_span_timer
`default_nettype wire

// ===== hw/sceh_error_handler.sv
/*
 * Communication error handler of the one-wire configuration link.
 * Assumes a frame front end on ref_clk that pulses the field events below,
 * and a raw line pin that is synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
module sceh_error_handler
	import sceh_pkg::*;
#(
	parameter int FIELD_CYC = sceh_pkg::FIELD_CYCLES
) (
	// Clock and reset.
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// Raw link line.
	input  wire logic                line_in,
	// Field events from the frame front end.
	input  wire logic                frame_start,
	input  wire logic                field_done,
	input  wire logic                frame_end,
	input  wire logic                evt_header_bad,
	input  wire logic                evt_rw_parity_bad,
	input  wire logic                evt_len_parity_bad,
	input  wire logic                evt_rw_reserved_nz,
	input  wire logic                evt_stop_low,
	// Write chunk checks.
	input  wire logic                wr_chunk_valid,
	input  wire logic                wr_chunk_csum_ok,
	// Status register read.
	input  wire logic                rd_req,
	input  wire logic [15:0]         rd_addr,
	input  wire logic                rd_single,
	// Results.
	output logic                     wr_commit,
	output logic                     rd_suppress,
	output logic                     xfer_abort,
	output logic [7:0]               rd_data,
	output sceh_pkg::sceh_state_e    link_state
);
	localparam int TW = 16;

	// The longer of the two spans must fit the timer width.
	if (FIELD_CYC < 1 || RECOVER_FIELDS * FIELD_CYC + 1 >= (1 << TW)) begin : g_bad_field_cyc
		$error("sceh_error_handler: FIELD_CYC out of range");
	end

	logic              line_s1_r;
	logic              line_s2_r;
	sceh_state_e       state_r;
	sceh_state_e       state_nxt;
	logic [FLAG_W-1:0] flags_r;
	logic [FLAG_W-1:0] flags_nxt;
	logic [FLAG_W-1:0] set_vec;
	logic              discard_r;
	logic              discard_nxt;
	logic              commit_r;
	logic              commit_nxt;
	logic              abort_r;
	logic              abort_nxt;
	logic [7:0]        rd_data_r;
	logic [7:0]        rd_data_nxt;
	logic              gap_expired;
	logic              rec_expired;
	logic              fatal;
	logic              live;
	logic              status_hit;
	logic              clear_req;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			line_s1_r <= 1'b1;
			line_s2_r <= 1'b1;
		end else begin
			line_s1_r <= line_in;
			line_s2_r <= line_s1_r;
		end
	end

	sceh_span_timer #(.W(TW), .LIMIT(GAP_FIELDS * FIELD_CYC)) u_gap (
		.ref_clk (ref_clk),
		.rst     (rst),
		.run     ((state_r == ST_COMM) && !field_done),
		.expired (gap_expired)
	);

	sceh_span_timer #(.W(TW), .LIMIT(RECOVER_FIELDS * FIELD_CYC)) u_rec (
		.ref_clk (ref_clk),
		.rst     (rst),
		.run     ((state_r == ST_ERROR) && line_s2_r),
		.expired (rec_expired)
	);

	assign live       = (state_r != ST_ERROR);
	assign status_hit = rd_req && (rd_addr == ERR_STATUS_ADDR);
	assign clear_req  = status_hit && rd_single;

	always_comb begin
		set_vec = '0;
		set_vec[BIT_FRAMING]    = live && evt_stop_low;
		set_vec[BIT_HEADER]     = live && evt_header_bad;
		set_vec[BIT_RW_PARITY]  = live && evt_rw_parity_bad;
		set_vec[BIT_LEN_PARITY] = live && evt_len_parity_bad;
		set_vec[BIT_CHECKSUM]   = (state_r == ST_COMM) && wr_chunk_valid && !wr_chunk_csum_ok
			&& !discard_r;
		set_vec[BIT_TIMEOUT]    = (state_r == ST_COMM) && gap_expired;
		set_vec[BIT_RW_DATA]    = live && evt_rw_reserved_nz;
	end

	assign fatal = |set_vec[BIT_CHECKSUM:BIT_FRAMING];

	always_comb begin
		state_nxt   = state_r;
		discard_nxt = discard_r;
		abort_nxt   = 1'b0;
		case (state_r)
			ST_STANDBY: begin
				discard_nxt = 1'b0;
				if (fatal) begin
					state_nxt = ST_ERROR;
					abort_nxt = 1'b1;
				end else if (frame_start) begin
					state_nxt = ST_COMM;
				end
			end
			ST_COMM: begin
				if (set_vec[BIT_RW_DATA]) begin
					discard_nxt = 1'b1;
				end
				if (fatal) begin
					state_nxt = ST_ERROR;
					abort_nxt = 1'b1;
				end else if (set_vec[BIT_TIMEOUT]) begin
					state_nxt = ST_STANDBY;
					abort_nxt = 1'b1;
				end else if (frame_end) begin
					state_nxt = ST_STANDBY;
				end
			end
			ST_ERROR: begin
				if (rec_expired) begin
					state_nxt   = ST_STANDBY;
					discard_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = ST_STANDBY;
			end
		endcase
	end

	always_comb begin
		commit_nxt = (state_r == ST_COMM) && wr_chunk_valid && wr_chunk_csum_ok
			&& !discard_r && !fatal && !gap_expired;
		flags_nxt = (clear_req ? {FLAG_W{1'b0}} : flags_r) | set_vec;
		rd_data_nxt = rd_data_r;
		if (status_hit) begin
			rd_data_nxt = {1'b0, flags_r};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_r   <= ST_STANDBY;
			flags_r   <= ERR_STATUS_RESET[FLAG_W-1:0];
			discard_r <= 1'b0;
			commit_r  <= 1'b0;
			abort_r   <= 1'b0;
			rd_data_r <= ERR_STATUS_RESET;
		end else begin
			state_r   <= state_nxt;
			flags_r   <= flags_nxt;
			discard_r <= discard_nxt;
			commit_r  <= commit_nxt;
			abort_r   <= abort_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end

	assign wr_commit   = commit_r;
	assign xfer_abort  = abort_r;
	assign rd_suppress = discard_r;
	assign rd_data     = rd_data_r;
	assign link_state  = state_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_fatal_in_comm;
		(state_r == ST_COMM) && fatal;
	endsequence
	sequence s_long_high;
		(state_r == ST_ERROR) && rec_expired;
	endsequence

	AST_RW_DATA_KEEPS_LINK: assert property (
		(state_r == ST_COMM) && evt_rw_reserved_nz && !fatal && !gap_expired && !frame_end
		|=> (state_r == ST_COMM) && discard_r && flags_r[BIT_RW_DATA])
		else $error("reserved bit error did not keep link open");
	AST_TIMEOUT_STANDBY: assert property (
		(state_r == ST_COMM) && gap_expired && !fatal
		|=> (state_r == ST_STANDBY) && flags_r[BIT_TIMEOUT] && xfer_abort)
		else $error("timeout did not return to standby");
	AST_CSUM_ERROR: assert property (
		(state_r == ST_COMM) && wr_chunk_valid && !wr_chunk_csum_ok && !discard_r
		|=> (state_r == ST_ERROR) && flags_r[BIT_CHECKSUM] && !wr_commit)
		else $error("checksum failure not handled");
	AST_LEN_PARITY: assert property (
		live && evt_len_parity_bad |=> (state_r == ST_ERROR) && flags_r[BIT_LEN_PARITY])
		else $error("length parity error not handled");
	AST_RW_PARITY: assert property (
		live && evt_rw_parity_bad |=> (state_r == ST_ERROR) && flags_r[BIT_RW_PARITY])
		else $error("read/write parity error not handled");
	AST_HEADER: assert property (
		live && evt_header_bad |=> (state_r == ST_ERROR) && flags_r[BIT_HEADER])
		else $error("header error not handled");
	AST_FRAMING: assert property (
		s_fatal_in_comm and evt_stop_low |=> xfer_abort && flags_r[BIT_FRAMING])
		else $error("framing error not handled");
	AST_GOOD_CHUNK_KEPT: assert property (
		(state_r == ST_COMM) && wr_chunk_valid && wr_chunk_csum_ok && !discard_r && !fatal
		&& !gap_expired |=> wr_commit)
		else $error("good chunk was not committed");
	AST_RECOVER: assert property (
		s_long_high |=> (state_r == ST_STANDBY))
		else $error("error mode not left after long high");
	AST_NO_EARLY_EXIT: assert property (
		(state_r == ST_ERROR) && !line_s2_r && !rec_expired
		|=> (state_r == ST_ERROR)[*2])
		else $error("error mode left while line low");
	AST_STICKY: assert property (
		!clear_req |=> (flags_r & $past(flags_r)) == $past(flags_r))
		else $error("flag dropped without clearing read");
	AST_MULTI_NO_CLEAR: assert property (
		status_hit && !rd_single |=> (flags_r & $past(flags_r)) == $past(flags_r)
		&& rd_data == {1'b0, $past(flags_r)})
		else $error("multi-byte read cleared flags");
	AST_READ_TOP_ZERO: assert property (
		status_hit |=> !rd_data[7])
		else $error("status bit 7 not zero");
	AST_ACCUMULATE: assert property (
		set_vec != 0 |=> (flags_r & $past(set_vec)) == $past(set_vec))
		else $error("set event lost");
endmodule : sceh_error_handler
`default_nettype wire

// ===== tb/sceh_line_host.sv
/*
 * Model of the link master's hold on the one-wire line.
 * Assumes the bench changes hold_low away from the rising clock edge.
 */
`timescale 1ns/1ns
`default_nettype none
module sceh_line_host (
	// Control.
	input  wire logic hold_low,
	// Line.
	output logic      line_in
);
	assign line_in = hold_low ? 1'b0 : 1'b1;
endmodule : sceh_line_host
`default_nettype wire

// ===== tb/tb.sv
/*
 * Self-checking bench of the communication error handler.
 * Assumes the package and the handler compile first; the field time is shortened.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
	import sceh_pkg::*;
	localparam int F = 4;
	logic        ref_clk     = 1'b0;
	logic        rst         = 1'b1;
	logic        hold_low    = 1'b0;
	logic [8:0]  ev          = 9'h000;
	logic        csum_ok     = 1'b0;
	logic        rd_req      = 1'b0;
	logic [15:0] rd_addr     = 16'h0000;
	logic        rd_single   = 1'b0;
	wire logic   line_in;
	logic        wr_commit;
	logic        rd_suppress;
	logic        xfer_abort;
	logic [7:0]  rd_data;
	sceh_state_e link_state;
	int          mismatches  = 0;
	int          num_checks  = 0;
	int          aborts      = 0;
	int          fk[4]       = '{7, 3, 4, 5};

	sceh_line_host host (.hold_low(hold_low), .line_in(line_in));

	sceh_error_handler #(.FIELD_CYC(F)) dut (
		.ref_clk(ref_clk), .rst(rst), .line_in(line_in),
		.frame_start(ev[0]), .field_done(ev[1]), .frame_end(ev[2]),
		.evt_header_bad(ev[3]), .evt_rw_parity_bad(ev[4]), .evt_len_parity_bad(ev[5]),
		.evt_rw_reserved_nz(ev[6]), .evt_stop_low(ev[7]),
		.wr_chunk_valid(ev[8]), .wr_chunk_csum_ok(csum_ok),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_single(rd_single),
		.wr_commit(wr_commit), .rd_suppress(rd_suppress), .xfer_abort(xfer_abort),
		.rd_data(rd_data), .link_state(link_state)
	);

	initial begin
		forever #20 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (xfer_abort === 1'b1) aborts++;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic st(input sceh_state_e e);
		chk({6'h00, link_state}, {6'h00, e});
	endtask : st

	task automatic pulse(input int k);
		@(negedge ref_clk);
		ev = 9'h001 << k;
		@(negedge ref_clk);
		ev = 9'h000;
	endtask : pulse

	task automatic rd(input logic [15:0] a, input logic s);
		@(negedge ref_clk);
		rd_req = 1'b1;
		rd_addr = a;
		rd_single = s;
		@(negedge ref_clk);
		rd_req = 1'b0;
	endtask : rd

	// The line is held low first so that a premature exit from Error shows.
	task automatic recover;
		hold_low = 1'b1;
		repeat (25) @(negedge ref_clk);
		st(ST_ERROR);
		hold_low = 1'b0;
		repeat (14) @(negedge ref_clk);
		st(ST_ERROR);
		repeat (12) @(negedge ref_clk);
		st(ST_STANDBY);
	endtask : recover

	task automatic end_of_test;
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		rd(ERR_STATUS_ADDR, 1'b1);
		chk(rd_data, ERR_STATUS_RESET);
		pulse(0);
		csum_ok = 1'b1;
		pulse(8);
		chk({7'h00, wr_commit}, 8'h01);
		csum_ok = 1'b0;
		pulse(8);
		chk({7'h00, wr_commit}, 8'h00);
		st(ST_ERROR);
		recover();
		chk(8'(aborts), 8'h01);
		for (int i = 0; i < 4; i++) begin
			pulse(0);
			pulse(fk[i]);
			st(ST_ERROR);
			// A reserved-bit event in Error must be ignored.
			pulse(6);
			recover();
		end
		chk(8'(aborts), 8'h05);
		rd(ERR_STATUS_ADDR, 1'b0);
		chk(rd_data, 8'h1f);
		rd(ERR_STATUS_ADDR - 16'h0001, 1'b1);
		chk(rd_data, 8'h1f);
		rd(ERR_STATUS_ADDR, 1'b1);
		chk(rd_data, 8'h1f);
		rd(ERR_STATUS_ADDR, 1'b1);
		chk(rd_data, 8'h00);
		pulse(0);
		csum_ok = 1'b1;
		pulse(8);
		chk({7'h00, wr_commit}, 8'h01);
		pulse(1);
		repeat (3 * F - 2) @(negedge ref_clk);
		st(ST_COMM);
		repeat (10) @(negedge ref_clk);
		st(ST_STANDBY);
		chk(8'(aborts), 8'h06);
		pulse(0);
		pulse(6);
		chk({7'h00, rd_suppress}, 8'h01);
		st(ST_COMM);
		pulse(8);
		chk({7'h00, wr_commit}, 8'h00);
		pulse(2);
		st(ST_STANDBY);
		rd(ERR_STATUS_ADDR, 1'b1);
		chk(rd_data, 8'h60);
		end_of_test();
	end

	initial begin
		repeat (2000) @(posedge ref_clk);
		mismatches++;
		end_of_test();
	end
endmodule : tb
`default_nettype wire
